// ---- verilog/sccp_top.sv ----
`timescale 1ns/1ps
`include "sccp_defines.svh"

// Function
// - Auto-zero level is P 8 upper byte then P 9 lower byte, CRLF ended.
// - Level is rebuilt as upper times 256 plus lower.
// - Each received level is scaled by the value multiplier before storing.
// - Fresh-air zero level uses selectors 10 upper and 11 lower.
// - '@' with two values sets initial then regular interval and echoes.
// - Both interval values are counted in tenths of a day.
// - '@ 0' disables automatic zeroing.
// - '@' alone reports the present auto-zero configuration.
// - 'S' stores compensation, default 8192, range 0 to 65536, echoed.
// - 's' returns the compensation value unchanged.
// - Output mask sums weights: filtered 4, unfiltered 2.
// - 'M' with value sets the mask; alone reports it, default 04164.
// - All enabled measurement fields go out in one line.
// - Every command and response line ends with CR then LF.
module sccp_top
    import sccp_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] co2_mult,
    input wire sccp_val_t co2_filt,
    input wire sccp_val_t co2_unf,
    input wire logic meas_valid,
    output sccp_cfg_s cfg
);

    // ****************************************************************
    // Line parser
    // ****************************************************************
    sccp_cfg_s cfg_r;
    logic [7:0] cmd_r;
    logic have_cmd_r;
    logic [19:0] acc_r;
    logic in_num_r;
    logic [1:0] cnt_r;
    logic [2:0][16:0] args_r;
    logic [7:0] az_hi_r;
    logic [7:0] fa_hi_r;

    wire rx_fire = rx_valid && rx_ready;
    wire is_lf = rx_data == `SCCP_CH_LF;
    wire is_cr = rx_data == `SCCP_CH_CR;
    wire is_sp = rx_data == `SCCP_CH_SP;
    wire is_dig = rx_data >= `SCCP_CH_ZERO && rx_data <= `SCCP_CH_NINE;
    wire [19:0] acc_nxt = 20'(acc_r * `SCCP_DEC_BASE)
        + 20'(rx_data - `SCCP_CH_ZERO);
    wire num_end = in_num_r && cnt_r != 2'h3;
    wire [1:0] cnt_eff = cnt_r + {1'b0, num_end};

    function automatic sccp_val_t arg_at(input logic [1:0] i);
        if (num_end && i == cnt_r) begin
            return acc_r[16:0];
        end
        return args_r[i];
    endfunction

    wire sccp_val_t a0 = arg_at(2'h0);
    wire sccp_val_t a1 = arg_at(2'h1);

    always_ff @(posedge mclk) begin
        if (!nrst || (rx_fire && is_lf)) begin
            have_cmd_r <= 1'b0;
            cmd_r <= 8'h00;
            acc_r <= 20'h00000;
            in_num_r <= 1'b0;
            cnt_r <= 2'h0;
            args_r <= '0;
        end else if (rx_fire && !have_cmd_r && !is_cr) begin
            have_cmd_r <= 1'b1;
            cmd_r <= rx_data;
        end else if (rx_fire && (is_sp || is_cr) && num_end) begin
            args_r[cnt_r] <= acc_r[16:0];
            cnt_r <= cnt_r + 2'h1;
            in_num_r <= 1'b0;
            acc_r <= 20'h00000;
        end else if (rx_fire && is_dig) begin
            // the point is skipped, so 1.0 counts as ten tenths
            acc_r <= acc_nxt;
            in_num_r <= 1'b1;
        end
    end

    // ****************************************************************
    // Command decode
    // ****************************************************************
    wire exec = rx_fire && is_lf && have_cmd_r;
    wire p_ok = cnt_eff == 2'h2 && a1 <= `SCCP_BYTE_MAX;
    wire p_az_hi = cmd_r == `SCCP_CH_P && p_ok && a0 == `SCCP_SEL_AZ_HI;
    wire p_az_lo = cmd_r == `SCCP_CH_P && p_ok && a0 == `SCCP_SEL_AZ_LO;
    wire p_fa_hi = cmd_r == `SCCP_CH_P && p_ok && a0 == `SCCP_SEL_FA_HI;
    wire p_fa_lo = cmd_r == `SCCP_CH_P && p_ok && a0 == `SCCP_SEL_FA_LO;
    wire p_any = p_az_hi || p_az_lo || p_fa_hi || p_fa_lo;
    wire at_cmd = cmd_r == `SCCP_CH_AT;
    wire at_rep = at_cmd && cnt_eff == 2'h0;
    wire at_off = at_cmd && cnt_eff == 2'h1 && a0 == 17'h00000;
    wire at_set = at_cmd && cnt_eff == 2'h2;
    wire s_set = cmd_r == `SCCP_CH_S && cnt_eff == 2'h1
        && a0 <= `SCCP_COMP_MAX;
    wire s_rep = cmd_r == `SCCP_CH_SL && cnt_eff == 2'h0;
    wire m_set = cmd_r == `SCCP_CH_M && cnt_eff == 2'h1;
    wire m_rep = cmd_r == `SCCP_CH_M && cnt_eff == 2'h0;
    wire cmd_ok = p_any || at_rep || at_off || at_set || s_set || s_rep
        || m_set || m_rep;

    // rebuild upper times 256 plus lower
    wire [15:0] az_word = {az_hi_r, a1[7:0]};
    wire [15:0] fa_word = {fa_hi_r, a1[7:0]};
    wire [23:0] az_scaled = 24'(az_word) * 24'(co2_mult);
    wire [23:0] fa_scaled = 24'(fa_word) * 24'(co2_mult);

    wire filt_on = cfg_r.mask[`SCCP_MASK_FILT];
    wire unf_on = cfg_r.mask[`SCCP_MASK_UNF];

    sccp_resp_s cmd_resp;
    sccp_resp_s meas_resp;

    always_comb begin
        cmd_resp = '0;
        cmd_resp.letter = cmd_r;
        if (p_any) begin
            cmd_resp.letter = `SCCP_CH_PL;
            cmd_resp.nfld = 2'h2;
            cmd_resp.val[0] = a0;
            cmd_resp.val[1] = a1;
            cmd_resp.fmt[0] = `SCCP_FMT_MIN;
            cmd_resp.fmt[1] = `SCCP_FMT_MIN;
        end else if (at_set || (at_rep && cfg_r.az_en)) begin
            cmd_resp.nfld = 2'h2;
            cmd_resp.val[0] = at_set ? a0 : cfg_r.az_init;
            cmd_resp.val[1] = at_set ? a1 : cfg_r.az_reg;
            cmd_resp.fmt[0] = `SCCP_FMT_TENTH;
            cmd_resp.fmt[1] = `SCCP_FMT_TENTH;
        end else if (at_cmd) begin
            cmd_resp.nfld = 2'h1;
            cmd_resp.fmt[0] = `SCCP_FMT_MIN;
        end else begin
            cmd_resp.nfld = 2'h1;
            cmd_resp.val[0] = (s_set || m_set) ? a0
                : (s_rep ? cfg_r.comp : cfg_r.mask);
            cmd_resp.fmt[0] = `SCCP_FMT_FIX;
        end
    end

    // every enabled field on one line
    always_comb begin
        meas_resp = '0;
        meas_resp.letter = `SCCP_CH_Z;
        meas_resp.nfld = {1'b0, filt_on} + {1'b0, unf_on};
        meas_resp.val[0] = filt_on ? co2_filt : co2_unf;
        meas_resp.val[1] = co2_unf;
        meas_resp.fmt[0] = `SCCP_FMT_FIX;
        meas_resp.fmt[1] = `SCCP_FMT_FIX;
    end

    // ****************************************************************
    // Configuration store
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg_r.az_level <= `SCCP_LEVEL_DEF;
            cfg_r.fa_level <= `SCCP_LEVEL_DEF;
            cfg_r.az_init <= `SCCP_AZ_INIT_DEF;
            cfg_r.az_reg <= `SCCP_AZ_REG_DEF;
            cfg_r.az_en <= 1'b1;
            cfg_r.comp <= `SCCP_COMP_DEF;
            cfg_r.mask <= `SCCP_MASK_DEF;
            az_hi_r <= 8'h00;
            fa_hi_r <= 8'h00;
        end else if (exec) begin
            // upper byte is held until its lower byte arrives
            if (p_az_hi) begin
                az_hi_r <= a1[7:0];
            end
            if (p_az_lo) begin
                cfg_r.az_level <= az_scaled;
            end
            if (p_fa_hi) begin
                fa_hi_r <= a1[7:0];
            end
            if (p_fa_lo) begin
                cfg_r.fa_level <= fa_scaled;
            end
            // intervals held in tenths of a day
            if (at_set) begin
                cfg_r.az_init <= a0;
                cfg_r.az_reg <= a1;
                cfg_r.az_en <= 1'b1;
            end
            if (at_off) begin
                cfg_r.az_en <= 1'b0;
            end
            if (s_set) begin
                cfg_r.comp <= a0;
            end
            // mask weights feed the field selection
            if (m_set) begin
                cfg_r.mask <= a0;
            end
        end
    end

    assign cfg = cfg_r;

    // ****************************************************************
    // Response emitter
    // ****************************************************************
    sccp_sq_e sq_r;
    sccp_resp_s resp_r;
    logic [1:0] fld_r;
    logic [2:0] di_r;
    logic dot_r;
    logic [7:0] tx_data_r;
    logic tx_valid_r;
    logic [19:0] bcd;

    // A measurement that lands while a line is going out is dropped,
    // since holding it would need a buffer we chose not to spend.
    wire meas_go = meas_valid && rx_ready && !exec
        && meas_resp.nfld != 2'h0;
    wire cmd_go = exec && cmd_ok;
    wire load = (!tx_valid_r || tx_ready) && sq_r != SQ_IDLE;
    wire [1:0] cur_fmt = resp_r.fmt[fld_r];
    wire last_fld = 2'(fld_r + 2'h1) >= resp_r.nfld;

    sccp_bcd u_bcd (
        .bin(resp_r.val[fld_r]),
        .bcd(bcd)
    );

    function automatic logic [3:0] dig_at(input logic [19:0] b,
                                          input logic [2:0] i);
        return b[4 * (`SCCP_DIG_LAST - i) +: 4];
    endfunction

    function automatic logic [2:0] start_at(input logic [19:0] b,
                                            input logic [1:0] f);
        logic [2:0] st;
        st = (f == `SCCP_FMT_TENTH) ? `SCCP_DIG_UNITS_TENTH
            : `SCCP_DIG_LAST;
        for (int i = 3; i >= 0; i--) begin
            if (3'(i) < st && dig_at(b, 3'(i)) != 4'h0) begin
                st = 3'(i);
            end
        end
        return (f == `SCCP_FMT_FIX) ? 3'h0 : st;
    endfunction

    wire need_dot = cur_fmt == `SCCP_FMT_TENTH && di_r == `SCCP_DIG_LAST
        && !dot_r;
    wire [7:0] dig_ch = `SCCP_CH_ZERO + {4'h0, dig_at(bcd, di_r)};

    // Kept low until the closing LF is taken, so lines never overlap.
    assign rx_ready = sq_r == SQ_IDLE && !tx_valid_r;
    assign tx_data = tx_data_r;
    assign tx_valid = tx_valid_r;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sq_r <= SQ_IDLE;
            resp_r <= '0;
            fld_r <= 2'h0;
            di_r <= 3'h0;
            dot_r <= 1'b0;
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
        end else begin
            if (tx_ready) begin
                tx_valid_r <= 1'b0;
            end
            if (load) begin
                tx_valid_r <= 1'b1;
            end
            unique case (sq_r)
                SQ_IDLE: begin
                    fld_r <= 2'h0;
                    if (cmd_go || meas_go) begin
                        resp_r <= cmd_go ? cmd_resp : meas_resp;
                        sq_r <= SQ_LET;
                    end
                end
                SQ_LET: if (load) begin
                    tx_data_r <= resp_r.letter;
                    sq_r <= (resp_r.nfld == 2'h0) ? SQ_CR : SQ_SP;
                end
                SQ_SP: if (load) begin
                    tx_data_r <= `SCCP_CH_SP;
                    di_r <= start_at(bcd, cur_fmt);
                    dot_r <= 1'b0;
                    sq_r <= SQ_DIG;
                end
                SQ_DIG: if (load) begin
                    if (need_dot) begin
                        tx_data_r <= `SCCP_CH_DOT;
                        dot_r <= 1'b1;
                    end else begin
                        tx_data_r <= dig_ch;
                        if (di_r == `SCCP_DIG_LAST) begin
                            fld_r <= fld_r + 2'h1;
                            sq_r <= last_fld ? SQ_CR : SQ_SP;
                        end else begin
                            di_r <= di_r + 3'h1;
                        end
                    end
                end
                // every line closes with CR then LF
                SQ_CR: if (load) begin
                    tx_data_r <= `SCCP_CH_CR;
                    sq_r <= SQ_LF;
                end
                SQ_LF: if (load) begin
                    tx_data_r <= `SCCP_CH_LF;
                    sq_r <= SQ_IDLE;
                end
                default: sq_r <= SQ_IDLE;
            endcase
        end
    end

endmodule // sccp_top

// ---- common/sccp_defines.svh ----
`ifndef SCCP_DEFINES_SVH
`define SCCP_DEFINES_SVH

// ****************************************************************
// Character codes
// ****************************************************************
`define SCCP_CH_CR 8'h0d
`define SCCP_CH_LF 8'h0a
`define SCCP_CH_SP 8'h20
`define SCCP_CH_DOT 8'h2e
`define SCCP_CH_ZERO 8'h30
`define SCCP_CH_NINE 8'h39
`define SCCP_CH_AT 8'h40
`define SCCP_CH_P 8'h50
`define SCCP_CH_PL 8'h70
`define SCCP_CH_S 8'h53
`define SCCP_CH_SL 8'h73
`define SCCP_CH_M 8'h4d
`define SCCP_CH_Z 8'h5a

// ****************************************************************
// Selectors, limits and defaults
// ****************************************************************
`define SCCP_SEL_AZ_HI 17'h00008
`define SCCP_SEL_AZ_LO 17'h00009
`define SCCP_SEL_FA_HI 17'h0000a
`define SCCP_SEL_FA_LO 17'h0000b
`define SCCP_BYTE_MAX 17'h000ff
`define SCCP_COMP_DEF 17'h02000
`define SCCP_COMP_MAX 17'h10000
`define SCCP_MASK_DEF 17'h01044
`define SCCP_MASK_FILT 2
`define SCCP_MASK_UNF 1
`define SCCP_LEVEL_DEF 24'h000190
`define SCCP_AZ_INIT_DEF 17'h0000a
`define SCCP_AZ_REG_DEF 17'h00050
`define SCCP_DEC_BASE 20'h0000a

// ****************************************************************
// Number formats and digit positions
// ****************************************************************
`define SCCP_FMT_FIX 2'h0
`define SCCP_FMT_MIN 2'h1
`define SCCP_FMT_TENTH 2'h2
`define SCCP_DIG_LAST 3'h4
`define SCCP_DIG_UNITS_TENTH 3'h3

`endif

// ---- common/sccp_pkg.sv ----
package sccp_pkg;

    typedef logic [16:0] sccp_val_t;

    typedef enum logic [5:0] {
        SQ_IDLE = 6'h01,
        SQ_LET = 6'h02,
        SQ_SP = 6'h04,
        SQ_DIG = 6'h08,
        SQ_CR = 6'h10,
        SQ_LF = 6'h20
    } sccp_sq_e;

    typedef struct packed {
        logic [7:0] letter;
        logic [1:0] nfld;
        logic [2:0][16:0] val;
        logic [2:0][1:0] fmt;
    } sccp_resp_s;

    typedef struct packed {
        logic [23:0] az_level;
        logic [23:0] fa_level;
        logic [16:0] az_init;
        logic [16:0] az_reg;
        logic az_en;
        logic [16:0] comp;
        logic [16:0] mask;
    } sccp_cfg_s;

endpackage

// ---- verilog/sccp_bcd.sv ----
`timescale 1ns/1ps

module sccp_bcd
    import sccp_pkg::*;
(
    input wire sccp_val_t bin,
    output logic [19:0] bcd
);

    // Shift-and-add-three; combinational so a digit is ready each cycle.
    always_comb begin
        logic [36:0] sh;
        sh = {20'h00000, bin};
        for (int i = 0; i < 17; i++) begin
            for (int d = 0; d < 5; d++) begin
                if (sh[17 + 4 * d +: 4] > 4'h4) begin
                    sh[17 + 4 * d +: 4] = 4'(sh[17 + 4 * d +: 4] + 4'h3);
                end
            end
            sh = {sh[35:0], 1'b0};
        end
        bcd = sh[36:17];
    end

endmodule // sccp_bcd

// ---- test/sccp_sva.sv ----
`timescale 1ns/1ps

// ****************************************
// Port checks for the command parser
// ****************************************
module sccp_sva
    import sccp_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic meas_valid,
    input wire sccp_cfg_s cfg
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic lf_in = rx_valid && rx_ready && rx_data == 8'h0a;
    wire logic fld_on = cfg.mask[2] || cfg.mask[1];

    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("tx char changed before it was taken");
    property p_busy;
        tx_valid |-> !rx_ready;
    endproperty
    a_busy: assert property (p_busy)
        else $error("rx open while a line goes out");
    property p_crlf;
        tx_valid && tx_ready && tx_data == 8'h0d
            |=> tx_valid && tx_data == 8'h0a;
    endproperty
    a_crlf: assert property (p_crlf)
        else $error("line feed missing after carriage return");
    property p_idle;
        tx_valid && tx_ready && tx_data == 8'h0a |=> !tx_valid && rx_ready;
    endproperty
    a_idle: assert property (p_idle)
        else $error("emitter not idle after line end");
    // A measurement line may close rx too, so both causes are allowed.
    property p_rxfall;
        $fell(rx_ready) |-> $past(lf_in) || $past(meas_valid);
    endproperty
    a_rxfall: assert property (p_rxfall)
        else $error("rx closed without a cause");
    property p_meas;
        meas_valid && rx_ready && !lf_in && fld_on
            |-> ##2 tx_valid && tx_data == 8'h5a;
    endproperty
    a_meas: assert property (p_meas)
        else $error("measurement line did not start");
    property p_mnone;
        meas_valid && rx_ready && !lf_in && !fld_on |-> ##2 !tx_valid;
    endproperty
    a_mnone: assert property (p_mnone)
        else $error("line sent with no field selected");
    property p_cfg;
        !$stable(cfg) |-> $past(lf_in);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("config changed without a line feed");
endmodule // sccp_sva

bind sccp_top sccp_sva u_sva (
    .mclk(mclk),
    .nrst(nrst),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_ready(rx_ready),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .meas_valid(meas_valid),
    .cfg(cfg)
);

// ---- test/sccp_host.sv ----
`timescale 1ns/1ps

// ****************************************
// Host controller model
// ****************************************
module sccp_host
    import sccp_pkg::*;
(
    input wire logic mclk,
    input wire logic slow,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    string cur = "";
    string lines[$];

    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end

    // In slow mode the sink stalls every other cycle.
    always @(posedge mclk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    always @(posedge mclk) begin
        if (tx_valid && tx_ready) begin
            cur = $sformatf("%s%c", cur, tx_data);
            if (tx_data == 8'h0a) begin
                lines.push_back(cur);
                cur = "";
            end
        end
    end

    task automatic send(input string s);
        string t = {s, "\r\n"};
        logic ok;
        for (int i = 0; i < t.len(); i++) begin
            rx_data <= t[i];
            rx_valid <= 1'b1;
            do begin
                @(negedge mclk);
                ok = rx_ready;
                @(posedge mclk);
            end while (!ok);
        end
        // A released data line shows the inverse, never a stale char.
        rx_valid <= 1'b0;
        rx_data <= ~t[t.len() - 1];
    endtask
endmodule // sccp_host

// ---- test/tb_top.sv ----
`timescale 1ns/1ps

// ****************************************
// Self-checking bench
// ****************************************
module tb_top
    import sccp_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic slow = 1'b0;
    logic [7:0] co2_mult = 8'h01;
    sccp_val_t co2_filt = 17'h00000;
    sccp_val_t co2_unf = 17'h00000;
    logic meas_valid = 1'b0;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic rx_valid;
    logic rx_ready;
    logic tx_valid;
    logic tx_ready;
    sccp_cfg_s cfg;
    int failures = 0;
    int n_compared = 0;
    string mc[3] = '{"6", "4", "2"};
    string ze[3] = '{"Z 00400 00398", "Z 00400", "Z 00398"};

    always #25 mclk = ~mclk;

    sccp_top dut (
        .mclk(mclk),
        .nrst(nrst),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .rx_ready(rx_ready),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready),
        .co2_mult(co2_mult),
        .co2_filt(co2_filt),
        .co2_unf(co2_unf),
        .meas_valid(meas_valid),
        .cfg(cfg)
    );

    sccp_host u_host (
        .mclk(mclk),
        .slow(slow),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .rx_ready(rx_ready),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

    function automatic string hx(input logic [23:0] v);
        return $sformatf("%h", v);
    endfunction

    task automatic check(input string seen, input string exp);
        n_compared++;
        if (seen != exp) begin
            failures++;
            $display("ERROR at %0t: saw %s expected %s", $time, seen, exp);
        end
    endtask

    task automatic rsp(input string cmd, input string exp);
        string got = "none";
        if (cmd != "") u_host.send(cmd);
        for (int i = 0; i < 300 && u_host.lines.size() == 0; i++)
            @(posedge mclk);
        if (u_host.lines.size() > 0) got = u_host.lines.pop_front();
        check(got, {exp, "\r\n"});
    endtask

    // Silence is judged over a fixed window, so a very late line is missed.
    task automatic quiet(input string cmd);
        if (cmd != "") u_host.send(cmd);
        repeat (40) @(posedge mclk);
        check(hx(24'(u_host.lines.size())), hx(24'h000000));
    endtask

    task automatic meas();
        @(posedge mclk);
        co2_filt <= 17'h00190;
        co2_unf <= 17'h0018e;
        meas_valid <= 1'b1;
        @(posedge mclk);
        meas_valid <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        check(hx(cfg.comp), hx(17'h02000));
        check(hx(cfg.mask), hx(17'h01044));
        check(hx({cfg.az_en, cfg.az_init}), hx({1'b1, 17'h0000a}));
        check(hx(cfg.az_reg), hx(17'h00050));
        rsp("M", "M 04164");
        rsp("s", "s 08192");
        rsp("S 65536", "S 65536");
        quiet("S 65537");
        rsp("s", "s 65536");
        check(hx(cfg.comp), hx(17'h10000));
        @(posedge mclk);
        co2_mult <= 8'h03;
        rsp("P 8 1", "p 8 1");
        rsp("P 9 144", "p 9 144");
        check(hx(cfg.az_level), hx(24'h0004b0));
        @(posedge mclk);
        co2_mult <= 8'h01;
        rsp("P 10 7", "p 10 7");
        rsp("P 11 208", "p 11 208");
        check(hx(cfg.fa_level), hx(24'h0007d0));
        slow <= 1'b1;
        rsp("@ 1.5 12.0", "@ 1.5 12.0");
        check(hx({cfg.az_init, 7'h00}), hx({17'h0000f, 7'h00}));
        check(hx(cfg.az_reg), hx(17'h00078));
        rsp("@", "@ 1.5 12.0");
        rsp("@ 0", "@ 0");
        check(hx(24'(cfg.az_en)), hx(24'h000000));
        rsp("@", "@ 0");
        slow <= 1'b0;
        quiet("K");
        for (int i = 0; i < 3; i++) begin
            rsp({"M ", mc[i]}, {"M 0000", mc[i]});
            meas();
            rsp("", ze[i]);
        end
        rsp("M 0", "M 00000");
        meas();
        quiet("");
        wrap_up();
    end
endmodule // tb_top
